// ---- hdl/interval_timer.sv ----
// The register offsets and the APB register port were decided locally.
`timescale 1ns/100ps
`default_nettype none
module interval_timer (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic pready,
    output logic pslverr,
    output logic [31:0] prdata,
    output logic timer_irq
);

    typedef struct packed {
        interval_timer_pkg::timer_cfg_type cfg;
        logic [15:0] count;
        logic irq;
    } timer_state_type;

    timer_state_type state_r;
    timer_state_type state_nxt;
    interval_timer_pkg::reg_write_type wr;
    logic tick;

    timer_apb_slave u_bus (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .pstrb(pstrb),
        .status_word_0({16'h0000, state_r.count}),
        .status_word_1({24'h000000, state_r.cfg.scale}),
        .status_word_2({16'h0000, state_r.cfg.period}),
        .status_word_3({31'h00000000, state_r.cfg.enable}),
        .pready(pready),
        .pslverr(pslverr),
        .prdata(prdata),
        .wr(wr)
    );

    // Divides the core clock by scale+1
    timer_prescaler u_presc (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .run(state_r.cfg.enable),
        .scale(state_r.cfg.scale),
        .tick(tick)
    );

    // Down-counter, reload and interrupt pulse; a software count write beats a tick
    always_comb begin
        state_nxt = state_r;
        state_nxt.irq = 1'b0; // [RULE5]
        if (wr.scale_we) begin
            state_nxt.cfg.scale = wr.wdata[7:0]; // [RULE2]
        end
        if (wr.period_we) begin
            state_nxt.cfg.period = wr.wdata[15:0];
        end
        if (wr.control_we) begin
            state_nxt.cfg.enable = wr.wdata[interval_timer_pkg::CTRL_ENABLE_BIT];
        end
        if (wr.count_we) begin
            state_nxt.count = wr.wdata[15:0];
        end else if (tick) begin
            if (state_r.count == 16'h0001 || state_r.count == 16'h0000) begin
                // Zero reached: request and reload in the same step
                state_nxt.irq = 1'b1; // [RULE3]
                state_nxt.count = state_r.cfg.period; // [RULE4]
            end else begin
                state_nxt.count = state_r.count - 16'h0001; // [RULE1]
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            state_r.cfg.enable <= interval_timer_pkg::ENABLE_RESET;
            state_r.cfg.scale <= interval_timer_pkg::SCALE_RESET;
            state_r.cfg.period <= interval_timer_pkg::PERIOD_RESET;
            state_r.count <= interval_timer_pkg::COUNT_RESET;
            state_r.irq <= 1'b0;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign timer_irq = state_r.irq;

endmodule // interval_timer
`default_nettype wire

// ---- hdl/interval_timer_pkg.sv ----
// Functional notes
// [RULE1] Hold a 16-bit down-counter, decremented once per n processor clock cycles.
// [RULE2] An 8-bit prescale setting holds n minus one.
// [RULE3] Raise a timer interrupt request when the down-counter reaches zero.
// [RULE4] On zero, reload the counter from the 16-bit period so interrupts repeat.
// [RULE5] Interrupt is a one-cycle pulse; prescale counter reloads on each expiry.
package interval_timer_pkg;

    localparam int unsigned COUNT_WIDTH = 16;
    localparam int unsigned SCALE_WIDTH = 8;
    localparam int unsigned ADDR_WIDTH = 12;

    // Register byte offsets
    localparam logic [11:0] COUNT_OFFSET = 12'h000;
    localparam logic [11:0] SCALE_OFFSET = 12'h004;
    localparam logic [11:0] PERIOD_OFFSET = 12'h008;
    localparam logic [11:0] CONTROL_OFFSET = 12'h00c;

    // Control register fields
    localparam int unsigned CTRL_ENABLE_BIT = 0;

    // Values after reset
    localparam logic [15:0] COUNT_RESET = 16'h0000;
    localparam logic [7:0] SCALE_RESET = 8'h00;
    localparam logic [15:0] PERIOD_RESET = 16'h0000;
    localparam logic ENABLE_RESET = 1'b0;

    typedef enum logic [1:0] {
        REG_COUNT = 2'h0,
        REG_SCALE = 2'h1,
        REG_PERIOD = 2'h2,
        REG_CONTROL = 2'h3
    } reg_sel_type;

    // Register write strobe bundle from the bus slave
    typedef struct packed {
        logic count_we;
        logic scale_we;
        logic period_we;
        logic control_we;
        logic [31:0] wdata;
    } reg_write_type;

    // Timer settings (enable, prescale, period) held inside the timer state register
    typedef struct packed {
        logic enable;
        logic [7:0] scale;
        logic [15:0] period;
    } timer_cfg_type;

endpackage : interval_timer_pkg

// ---- hdl/timer_prescaler.sv ----
`timescale 1ns/100ps
`default_nettype none
module timer_prescaler (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic run,
    input wire logic [7:0] scale,
    output logic tick
);

    typedef struct packed {
        logic [7:0] cnt;
    } presc_state_type;

    presc_state_type state_r;
    presc_state_type state_nxt;

    // Tick fires when the counter has run through scale+1 cycles
    assign tick = run && (state_r.cnt == 8'h00); // [RULE2]

    // Count down, reload n-1 on expiry; held at setting while stopped
    always_comb begin
        state_nxt = state_r;
        if (!run) begin
            state_nxt.cnt = scale;
        end else if (state_r.cnt == 8'h00) begin
            state_nxt.cnt = scale; // [RULE5]
        end else begin
            state_nxt.cnt = state_r.cnt - 8'h01;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            state_r <= '{cnt: interval_timer_pkg::SCALE_RESET};
        end else begin
            state_r <= state_nxt;
        end
    end

endmodule // timer_prescaler
`default_nettype wire

// ---- hdl/timer_apb_slave.sv ----
`timescale 1ns/100ps
`default_nettype none
module timer_apb_slave (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] status_word_0,
    input wire logic [31:0] status_word_1,
    input wire logic [31:0] status_word_2,
    input wire logic [31:0] status_word_3,
    output logic pready,
    output logic pslverr,
    output logic [31:0] prdata,
    output interval_timer_pkg::reg_write_type wr
);

    // Maps a byte address to a register, flagging unmapped ones
    function automatic logic decode(input logic [11:0] a, output interval_timer_pkg::reg_sel_type sel);
        decode = 1'b1;
        sel = interval_timer_pkg::REG_COUNT;
        case (a)
            interval_timer_pkg::COUNT_OFFSET: sel = interval_timer_pkg::REG_COUNT;
            interval_timer_pkg::SCALE_OFFSET: sel = interval_timer_pkg::REG_SCALE;
            interval_timer_pkg::PERIOD_OFFSET: sel = interval_timer_pkg::REG_PERIOD;
            interval_timer_pkg::CONTROL_OFFSET: sel = interval_timer_pkg::REG_CONTROL;
            default: decode = 1'b0;
        endcase
    endfunction

    interval_timer_pkg::reg_sel_type sel;
    logic hit;
    logic access;
    logic [31:0] rdata_nxt;

    // Zero-wait slave: every access phase completes at once
    assign pready = 1'b1;
    assign access = psel && penable;

    always_comb begin
        hit = decode(paddr, sel);
        pslverr = access && !hit;
        wr.wdata = pwdata;
        // Writes need all lanes; partial strobes are ignored to keep fields coherent
        wr.count_we = access && pwrite && hit && (pstrb == 4'hf) && (sel == interval_timer_pkg::REG_COUNT);
        wr.scale_we = access && pwrite && hit && (pstrb == 4'hf) && (sel == interval_timer_pkg::REG_SCALE);
        wr.period_we = access && pwrite && hit && (pstrb == 4'hf) && (sel == interval_timer_pkg::REG_PERIOD);
        wr.control_we = access && pwrite && hit && (pstrb == 4'hf) && (sel == interval_timer_pkg::REG_CONTROL);
        case (sel)
            interval_timer_pkg::REG_COUNT: rdata_nxt = status_word_0;
            interval_timer_pkg::REG_SCALE: rdata_nxt = status_word_1;
            interval_timer_pkg::REG_PERIOD: rdata_nxt = status_word_2;
            default: rdata_nxt = status_word_3;
        endcase
        if (!hit) begin
            rdata_nxt = 32'h0000_0000;
        end
    end

    // Read data registered in setup, valid for the access phase
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            prdata <= rdata_nxt;
        end
    end

endmodule // timer_apb_slave
`default_nettype wire

// ---- sim/timer_checker.sv ----
`timescale 1ns/100ps
`default_nettype none
module timer_checker (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [31:0] prdata,
    input wire logic timer_irq
);
    logic run_r;
    logic scale_zero_r;
    logic period_small_r;
    logic fast_now;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    // Enable bit mirrored from bus writes
    always_ff @(posedge core_clk) begin
        if (!rst_n)
            run_r <= 1'b0;
        else if (psel && penable && pwrite && paddr == 12'h00c && pstrb == 4'hf)
            run_r <= pwdata[0];
    end
    // Scale 0 with period 0 or 1 ticks out a request every cycle, so pulses may touch
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            scale_zero_r <= 1'b1;
            period_small_r <= 1'b1;
        end else if (psel && penable && pwrite && pstrb == 4'hf) begin
            if (paddr == 12'h004) begin
                scale_zero_r <= (pwdata[7:0] == 8'h00);
            end
            if (paddr == 12'h008) begin
                period_small_r <= (pwdata[15:0] <= 16'h0001);
            end
        end
    end
    assign fast_now = scale_zero_r && period_small_r;
    a_ready_always: assert property (psel && penable |-> pready)
        else $error("pready low");
    a_unmapped_err: assert property (psel && penable && paddr > 12'h00f |-> pslverr && (pwrite || prdata == 32'h0))
        else $error("unmapped not refused");
    a_upper_zero: assert property (psel && penable && !pwrite |-> prdata[31:16] == 16'h0)
        else $error("upper bits set");
    // Old settings linger one cycle in the prescaler and reload path, hence the past term
    a_irq_pulse: assert property (timer_irq && !fast_now && !$past(fast_now) |=> !timer_irq)
        else $error("irq too long");
    // One cycle of grace: a tick may land as enable drops
    a_irq_needs_run: assert property (!run_r && !$past(run_r) |-> !timer_irq)
        else $error("irq while stopped");
    cover property (timer_irq);
    cover property (psel && penable && pslverr);
    cover property (psel && penable && pwrite && pstrb != 4'hf);
endmodule // timer_checker
bind interval_timer timer_checker chk_u (
    .core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .pslverr(pslverr), .prdata(prdata), .timer_irq(timer_irq)
);
`default_nettype wire

// ---- sim/testbench.sv ----
`timescale 1ns/100ps
`default_nettype none
module testbench;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'hf;
    logic [31:0] prdata, rd, v;
    logic pready, pslverr, timer_irq, er;
    int n_fail = 0;
    int n_tests = 0;
    int s, p, g;

    always #12.5 core_clk = ~core_clk;

    interval_timer dut_u (
        .core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .pslverr(pslverr), .prdata(prdata), .timer_irq(timer_irq)
    );

    task automatic final_report();
        if (n_fail == 0 && n_tests > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %0t got %h want %h", $time, got, exp);
        end
    endtask

    task automatic hang();
        n_fail++;
        $display("[ERR] %0t timeout", $time);
        final_report();
    endtask

    // One transfer; request held until pready seen at an edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge core_clk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (pready !== 1'b1)
            hang();
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic irq_wait(output int c);
        c = 0;
        do begin
            @(posedge core_clk);
            c++;
        end while (timer_irq !== 1'b1 && c < 3000);
        if (timer_irq !== 1'b1)
            hang();
    endtask

    function automatic logic [31:0] gap(input int pr, input int sc);
        return pr * (sc + 1);
    endfunction

    initial begin
        void'($urandom(46152));
        repeat (5) @(posedge core_clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            apb(1'b0, 12'(i * 4), 32'h0);
            chk(rd, 32'h0);
        end
        // Random readback, bits above the field read zero
        for (int i = 0; i < 3; i++) begin
            v = $urandom;
            apb(1'b1, 12'(i * 4), v);
            apb(1'b0, 12'(i * 4), 32'h0);
            chk(rd, v & ((i == 1) ? 32'hff : 32'hffff));
        end
        // Partial strobes must leave the period alone
        pstrb <= 4'h3;
        apb(1'b1, 12'h008, ~v);
        pstrb <= 4'hf;
        apb(1'b0, 12'h008, 32'h0);
        chk(rd, v & 32'hffff);
        apb(1'b1, 12'h010, v);
        chk({31'h0, er}, 32'h1);
        apb(1'b0, 12'h010, 32'h0);
        chk(rd, 32'h0);
        // Interrupt spacing; corners of the prescale first
        for (int i = 0; i < 5; i++) begin
            s = (i == 0) ? 0 : (i == 1) ? 255 : $urandom_range(15);
            p = $urandom_range(9, 2);
            apb(1'b1, 12'h00c, 32'h0);
            apb(1'b1, 12'h004, 32'(s));
            apb(1'b1, 12'h008, 32'(p));
            apb(1'b1, 12'h000, 32'(p));
            apb(1'b1, 12'h00c, 32'h1);
            irq_wait(g);
            @(posedge core_clk);
            chk({31'h0, timer_irq}, 32'h0);
            irq_wait(g);
            chk(32'(g + 1), gap(p, s));
            // Slow prescale leaves time to see the reloaded count
            if (i == 1) begin
                apb(1'b0, 12'h000, 32'h0);
                chk(rd, 32'(p));
            end
        end
        // Enable reads back, and a stopped timer keeps its count
        apb(1'b0, 12'h00c, 32'h0);
        chk(rd, 32'h1);
        apb(1'b1, 12'h00c, 32'h0);
        apb(1'b1, 12'h000, 32'h1234);
        repeat (40) @(posedge core_clk);
        apb(1'b0, 12'h000, 32'h0);
        chk(rd, 32'h1234);
        final_report();
    end
endmodule // testbench
`default_nettype wire
